// [rtl/swd_pkg.sv]
package swd_pkg;
  // clock and reference tick
  localparam int CLK_PERIOD_NS  = 10;                            // 100 MHz system clock
  localparam int TICK_NS        = 1000;                          // reference tick, 1 us
  localparam int TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;       // clocks per tick
  // reset hold interval, least time
  localparam int RESET_HOLD_MS    = 140;
  localparam int RESET_HOLD_TICKS = (RESET_HOLD_MS * 1000 * 1000 + TICK_NS - 1) / TICK_NS;
  // watchdog period, typical figure, with its limits
  localparam int WATCHDOG_PERIOD_MIN_MS = 1120;
  localparam int WATCHDOG_PERIOD_MS     = 1600;
  localparam int WATCHDOG_PERIOD_MAX_MS = 3200;
  localparam int WATCHDOG_TICKS         = (WATCHDOG_PERIOD_MS * 1000) / (TICK_NS / 1000);
  // manual input timing
  localparam int MANUAL_PULSE_MIN_NS       = 1000;
  localparam int MANUAL_NOISE_NS           = 100;
  localparam int MANUAL_TO_RESET_DELAY_NS  = 5000;
  localparam int MANUAL_DEBOUNCE_CYCLES    = MANUAL_PULSE_MIN_NS / (2 * CLK_PERIOD_NS);
  localparam int MANUAL_TO_RESET_CYCLES    = MANUAL_TO_RESET_DELAY_NS / CLK_PERIOD_NS;
  // strobe and supply input timing
  localparam int STROBE_PULSE_MIN_NS   = 50;
  localparam int STROBE_FILTER_CYCLES  = STROBE_PULSE_MIN_NS / (2 * CLK_PERIOD_NS);
  localparam int SUPPLY_FILTER_CYCLES  = 1;
  localparam int PULL_SETTLE_CYCLES    = 8;                      // pin path latency guard
  // widths and reset values
  localparam int CNT_W      = 22;
  localparam int SETTLE_W   = 4;
  localparam int TICK_W     = 8;
  localparam int LOWCNT_W   = 12;
  localparam bit SUPPLY_RST = 1'b0;
  localparam bit MANUAL_RST = 1'b1;
  localparam bit STROBE_RST = 1'b0;

  // filtered input levels
  typedef struct packed {
    logic supply_good;
    logic manual_n;
    logic strobe;
  } swd_in_s;

  // sequencing states
  typedef enum logic [1:0] {
    ST_ASSERT = 2'b00,
    ST_HOLD   = 2'b01,
    ST_RUN    = 2'b10
  } swd_state_e;
endpackage

// [rtl/swd_filter.sv]
`timescale 1ns/1ns
module swd_filter #(
  parameter int STABLE    = 1,
  parameter bit RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // asynchronous pin and its filtered level
  input  wire logic pin,
  output logic      level
);
  import swd_pkg::*;

  logic              sync1_reg;   // first stage, read only by second
  logic              sync2_reg;   // second stage
  logic [TICK_W-1:0] stab_reg;    // cycles the new level has held

  // two-flop synchroniser
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_reg <= RESET_VAL;
      sync2_reg <= RESET_VAL;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
    end
  end

  // accept a new level only after it held STABLE cycles
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stab_reg <= '0;
      level    <= RESET_VAL;
    end else if (sync2_reg == level) begin
      stab_reg <= '0;
    end else if (stab_reg >= TICK_W'(STABLE - 1)) begin
      stab_reg <= '0;
      level    <= sync2_reg;
    end else begin
      stab_reg <= stab_reg + 1'b1;
    end
  end
endmodule

// [rtl/swd_top.sv]
`timescale 1ns/1ns
module swd_top #(
  parameter int HOLD_TICKS = swd_pkg::RESET_HOLD_TICKS,   // hold interval in 1 us ticks
  parameter int WD_TICKS   = swd_pkg::WATCHDOG_TICKS,     // watchdog period in 1 us ticks
  parameter int TICK_DIV   = swd_pkg::TICK_CYCLES         // clocks per reference tick
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // supply comparator and manual request pins
  input  wire logic supply_good,
  input  wire logic manual_reset_n,
  // watchdog strobe pin, input side and pull driver
  input  wire logic watchdog_strobe_in,
  output logic      strobe_pull_out,
  output logic      strobe_pull_oe_n,
  // reset outputs to the processor
  output logic      reset_n,
  output logic      reset
);
  import swd_pkg::*;

  localparam logic [CNT_W-1:0] HOLD_END  = CNT_W'(HOLD_TICKS);
  localparam logic [CNT_W-1:0] WD_END    = CNT_W'(WD_TICKS);
  localparam logic [CNT_W-1:0] PULL_HIGH = CNT_W'(WD_TICKS - WD_TICKS / 8);
  localparam logic [TICK_W-1:0] TICK_END = TICK_W'(TICK_DIV - 1);

  swd_in_s           in_q;          // filtered pin levels
  swd_state_e        state_reg;     // sequencing state
  swd_state_e        state_next;    // next sequencing state
  logic [TICK_W-1:0] div_reg;       // reference tick divider
  logic              tick_reg;      // one-cycle tick enable
  logic [CNT_W-1:0]  hold_reg;      // hold interval count
  logic [CNT_W-1:0]  wd_reg;        // watchdog period count
  logic              strobe_d_reg;  // strobe level one cycle back
  logic              strobe_edge;   // either edge on the strobe
  logic              wd_expire;     // watchdog ran out
  logic              hold_done;     // hold interval over
  logic              cause;         // supply low or manual held
  logic              pull_val;      // level the pull pattern wants
  logic [SETTLE_W-1:0] settle_reg;  // cycles since pull changed
  logic              ext_reg;       // external driver seen on strobe

  // supply comparator, synchronised
  swd_filter #(.STABLE(SUPPLY_FILTER_CYCLES), .RESET_VAL(SUPPLY_RST)) u_supply (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (supply_good),
    .level (in_q.supply_good)
  );

  // manual request, synchronised and debounced
  swd_filter #(.STABLE(MANUAL_DEBOUNCE_CYCLES), .RESET_VAL(MANUAL_RST)) u_manual (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (manual_reset_n),
    .level (in_q.manual_n)
  );

  // watchdog strobe, synchronised with a short glitch filter
  swd_filter #(.STABLE(STROBE_FILTER_CYCLES), .RESET_VAL(STROBE_RST)) u_strobe (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (watchdog_strobe_in),
    .level (in_q.strobe)
  );

  // free-running reference tick divider
  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == TICK_END) begin
      div_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  // strobe edge detector on the filtered level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strobe_d_reg <= STROBE_RST;
    end else begin
      strobe_d_reg <= in_q.strobe;
    end
  end

  assign strobe_edge = in_q.strobe ^ strobe_d_reg;
  // reset causes: supply below trip or manual input held low
  assign cause       = !in_q.supply_good || !in_q.manual_n;
  assign hold_done   = tick_reg && (hold_reg == HOLD_END);
  assign wd_expire   = tick_reg && (wd_reg == WD_END) && !strobe_edge;

  // next-state decision
  always_comb begin
    state_next = state_reg;
    if (cause) begin
      state_next = ST_ASSERT;
    end else begin
      case (state_reg)
        // causes gone: start the hold interval
        ST_ASSERT: begin
          state_next = ST_HOLD;
        end
        // hold interval running
        ST_HOLD: begin
          if (hold_done) begin
            state_next = ST_RUN;
          end
        end
        // released: watchdog may pull back into hold
        ST_RUN: begin
          if (wd_expire) begin
            state_next = ST_HOLD;
          end
        end
        default: begin
          state_next = ST_ASSERT;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= ST_ASSERT;
    end else begin
      state_reg <= state_next;
    end
  end

  // reset outputs, registered and always complementary
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reset_n <= 1'b0;
      reset   <= 1'b1;
    end else begin
      reset_n <= (state_next == ST_RUN);
      reset   <= (state_next != ST_RUN);
    end
  end

  // hold interval counter, cleared outside the hold state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hold_reg <= '0;
    end else if (state_next != ST_HOLD || state_reg != ST_HOLD) begin
      hold_reg <= '0;
    end else if (tick_reg) begin
      hold_reg <= hold_reg + 1'b1;
    end
  end

  // watchdog counter, runs only while reset is released
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wd_reg <= '0;
    end else if (state_reg != ST_RUN || state_next != ST_RUN) begin
      wd_reg <= '0;
    end else if (strobe_edge) begin
      wd_reg <= '0;
    end else if (tick_reg) begin
      wd_reg <= wd_reg + 1'b1;
    end
  end

  // pull pattern: low for 7/8 of the period, high for the last 1/8
  assign pull_val = (wd_reg >= PULL_HIGH);

  // settle guard after every change of the pulled level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      settle_reg <= '0;
    end else if (pull_val != strobe_pull_out) begin
      settle_reg <= '0;
    end else if (settle_reg != SETTLE_W'(PULL_SETTLE_CYCLES)) begin
      settle_reg <= settle_reg + 1'b1;
    end
  end

  // external driver detection: pin disagrees with a settled pull
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ext_reg <= 1'b0;
    end else if (state_reg != ST_RUN) begin
      ext_reg <= 1'b0;                                        // retry pulling after reset
    end else if (!strobe_pull_oe_n && settle_reg == SETTLE_W'(PULL_SETTLE_CYCLES)
                 && in_q.strobe != strobe_pull_out) begin
      ext_reg <= 1'b1;
    end
  end

  // pull driver, released once an external driver is seen, until the next reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strobe_pull_out  <= 1'b0;
      strobe_pull_oe_n <= 1'b1;
    end else begin
      strobe_pull_out  <= pull_val;
      strobe_pull_oe_n <= ext_reg;
    end
  end

  // checking helpers: cycles the raw manual pin has been low
  logic [LOWCNT_W-1:0] man_low_cnt;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      man_low_cnt <= '0;
    end else if (manual_reset_n) begin
      man_low_cnt <= '0;
    end else if (man_low_cnt != {LOWCNT_W{1'b1}}) begin
      man_low_cnt <= man_low_cnt + 1'b1;
    end
  end

  // checking helper: ticks spent in reset since the causes went away
  logic [CNT_W-1:0] rel_ticks;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rel_ticks <= '0;
    end else if (cause || reset_n) begin
      rel_ticks <= '0;                                        // restart on any cause or release
    end else if (tick_reg && rel_ticks != {CNT_W{1'b1}}) begin
      rel_ticks <= rel_ticks + 1'b1;                          // saturate, never wrap
    end
  end

  // checks share one clock and drop out during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // steps of a hold end and of a watchdog expiry
  sequence s_hold_end;
    state_reg == ST_HOLD && hold_done && !cause;
  endsequence

  sequence s_wd_expiry;
    state_reg == ST_RUN && wd_expire && !cause;
  endsequence

  // release only after the full hold interval
  chk_hold_release: assert property ($rose(reset_n) |-> $past(hold_reg) == HOLD_END)
    else $error("reset released before hold interval ended");
  chk_hold_to_run: assert property (s_hold_end |=> reset_n && state_reg == ST_RUN)
    else $error("hold end did not release reset");
  chk_hold_min: assert property ($rose(reset_n) |-> rel_ticks >= CNT_W'(HOLD_TICKS))
    else $error("reset released after too few hold ticks");
  chk_hold_cleared: assert property (state_reg != ST_HOLD |=> hold_reg == '0)
    else $error("hold count not restarted outside hold");

  // causes force and keep reset
  chk_supply_low: assert property (!in_q.supply_good |=> !reset_n && hold_reg == '0)
    else $error("supply low did not assert reset");
  chk_manual_held: assert property (!in_q.manual_n |=> state_reg == ST_ASSERT && reset)
    else $error("manual low did not hold reset");
  chk_manual_delay: assert property (man_low_cnt == LOWCNT_W'(MANUAL_TO_RESET_CYCLES) |-> !reset_n)
    else $error("manual request too slow to reset");
  chk_noise_reject: assert property ($fell(in_q.manual_n) |-> man_low_cnt >= LOWCNT_W'(MANUAL_DEBOUNCE_CYCLES))
    else $error("short manual pulse accepted");

  // reset output against run state, watchdog count and expiry
  chk_run_out: assert property (reset_n == (state_reg == ST_RUN))
    else $error("reset output does not follow run state");
  chk_wd_stopped: assert property (state_reg != ST_RUN |=> wd_reg == '0)
    else $error("watchdog counted during reset");
  chk_edge_clear: assert property (state_reg == ST_RUN && strobe_edge |=> wd_reg == '0)
    else $error("strobe edge did not restart watchdog");
  chk_wd_bound: assert property (wd_reg <= WD_END)
    else $error("watchdog count ran past its end");
  chk_wd_expiry: assert property (s_wd_expiry |=> !reset_n ##1 hold_reg == '0 && state_reg == ST_HOLD)
    else $error("watchdog expiry did not start hold");
  chk_expiry_restart: assert property (s_wd_expiry |=> wd_reg == '0 && reset)
    else $error("watchdog not restarted after expiry");

  // pull pattern and external drive
  chk_pull_low: assert property (wd_reg < PULL_HIGH |=> !strobe_pull_out)
    else $error("pull high before seven eighths");
  chk_pull_phase: assert property (state_reg == ST_RUN && $rose(pull_val) |=> strobe_pull_out
                                   && $past(wd_reg) == PULL_HIGH)
    else $error("pull high not at seven eighths");
  chk_pull_release: assert property (ext_reg |=> strobe_pull_oe_n)
    else $error("pull kept driving against external driver");
  chk_ext_cleared: assert property (state_reg != ST_RUN |=> !ext_reg ##1 !strobe_pull_oe_n)
    else $error("pull not retried after reset");

  // output pair
  chk_out_pair: assert property (reset == !reset_n)
    else $error("reset outputs not complementary");
endmodule

// [verif/swd_host_model.sv]
`timescale 1ns/1ns
// far side: pushbutton, strobing processor and the shared reset wire
module swd_host_model (
  // testbench commands
  input  wire logic clk,
  input  wire logic button_down,
  input  wire logic strobe_en,
  input  wire logic strobe_val,
  input  wire logic proc_pull,
  // device pins
  input  wire logic strobe_pull_out,
  input  wire logic strobe_pull_oe_n,
  input  wire logic reset_n,
  output logic      manual_reset_n,
  output logic      watchdog_strobe_in,
  output logic      reset_line
);
  logic float_lvl = 1'b0;  // an open pin shows the inverse of its last level

  // pull-up idles the manual pin high, the button drives it low
  assign manual_reset_n = ~button_down;
  // external driver wins, then the device pull, else the floating pattern
  assign watchdog_strobe_in = strobe_en ? strobe_val : (!strobe_pull_oe_n ? strobe_pull_out : float_lvl);
  // floating level changes every cycle so no stale value survives
  always @(posedge clk) float_lvl <= ~watchdog_strobe_in;
  // processor may pull the reset wire low over the device drive
  assign reset_line = reset_n & ~proc_pull;
endmodule

// [verif/test_supervisory_reset_watchdog.sv]
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin failures++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module test_supervisory_reset_watchdog;
  import swd_pkg::*;
  localparam int HT = 20;       // hold ticks
  localparam int WT = 64;       // watchdog ticks
  localparam int TD = 4;        // clocks per tick
  localparam int HC = HT * TD;  // hold in clocks
  typedef struct {int width; logic hit;} swd_row_s;
  swd_row_s rows [4] = '{'{10, 1'b0}, '{30, 1'b0}, '{100, 1'b1}, '{300, 1'b1}};
  logic clk = 0, rstn = 0, supply_good = 0, button_down = 0, strobe_en = 0, strobe_val = 0, proc_pull = 0;
  logic manual_reset_n, watchdog_strobe_in, strobe_pull_out, strobe_pull_oe_n, reset_n, reset, reset_line;
  int   failures = 0, samples_checked = 0, n, k, hi, first, last;

  // free-running clock
  always #5 clk = ~clk;
  // outputs stay complementary
  // outputs stay complementary, looked at on the falling edge where they are settled
  always @(negedge clk) if (rstn) `CHK("reset", ~reset_n, reset)

  swd_top #(.HOLD_TICKS(HT), .WD_TICKS(WT), .TICK_DIV(TD)) DUT (.clk(clk), .rstn(rstn),
    .supply_good(supply_good), .manual_reset_n(manual_reset_n), .watchdog_strobe_in(watchdog_strobe_in),
    .strobe_pull_out(strobe_pull_out), .strobe_pull_oe_n(strobe_pull_oe_n), .reset_n(reset_n), .reset(reset));
  swd_host_model u_host (.clk(clk), .button_down(button_down), .strobe_en(strobe_en), .strobe_val(strobe_val),
    .proc_pull(proc_pull), .strobe_pull_out(strobe_pull_out), .strobe_pull_oe_n(strobe_pull_oe_n),
    .reset_n(reset_n), .manual_reset_n(manual_reset_n), .watchdog_strobe_in(watchdog_strobe_in),
    .reset_line(reset_line));

  // verdict and end of run
  task stop_test;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // idle for c falling edges
  task cyc(input int c);
    repeat (c) @(negedge clk);
  endtask
  // bounded wait for reset_n to reach v, n counts clocks
  task wait_rst(input logic v, input int lim);
    n = 0;
    while (reset_n !== v) begin
      cyc(1);
      n++;
      if (n > lim) begin
        failures++;
        $display("mismatch wait_reset expected %0h seen %0h", v, reset_n);
        stop_test();
      end
    end
  endtask

  // main sequence
  initial begin
    cyc(20);
    `CHK("rst_out", 1'b0, reset_n)
    `CHK("rst_oe", 1'b1, strobe_pull_oe_n)
    rstn = 1;
    cyc(50);
    `CHK("no_supply", 1'b0, reset_n)
    supply_good = 1;
    wait_rst(1, 150);
    `CHK("power_hold", 1'b1, n >= HC && n <= HC + 20)
    // manual pulses of several widths
    foreach (rows[i]) begin
      first = -1;
      last = -1;
      for (k = 0; k < 500; k++) begin
        button_down = (k < rows[i].width);
        cyc(1);
        if (!reset_n) begin
          if (first < 0) first = k;
          last = k;
        end
      end
      `CHK("manual_hit", rows[i].hit, first >= 0)
      if (rows[i].hit) `CHK("manual_hold", 1'b1, last >= rows[i].width + HC)
      wait_rst(1, 200);
    end
    // floating strobe services itself with brief high pulls
    first = -1;
    hi = 0;
    for (k = 0; k < 1000; k++) begin
      cyc(1);
      hi += strobe_pull_out;
      if (!reset_n) first = k;
    end
    `CHK("float_reset", -1, first)
    `CHK("float_pull", 1'b1, hi > 0 && hi < 125)
    `CHK("float_oe", 1'b0, strobe_pull_oe_n)
    // processor edges keep the watchdog quiet
    strobe_en = 1;
    first = -1;
    for (k = 0; k < 1200; k++) begin
      strobe_val = (k % 100 < 5);
      cyc(1);
      if (!reset_n) first = k;
    end
    `CHK("serviced", -1, first)
    // held strobe: expiry, hold, restart from zero
    button_down = 1;
    cyc(520);  // held past the 5 us bound so the delay check is reached
    button_down = 0;
    wait_rst(1, 300);
    for (k = 0; k < 2; k++) begin
      cyc(245);
      `CHK("ext_drive_oe", 1'b1, strobe_pull_oe_n)
      wait_rst(0, 40);
      `CHK("expiry", 1'b1, n + 245 >= WT * TD - 8 && n + 245 <= WT * TD + 16)
      wait_rst(1, 150);
      `CHK("expiry_hold", 1'b1, n >= HC && n <= HC + 20)
    end
    // processor pulls the shared reset wire low over the released output
    proc_pull = 1;
    cyc(1);
    `CHK("proc_pull", 1'b0, reset_line)
    `CHK("proc_dev", 1'b1, reset_n)
    proc_pull = 0;
    cyc(1);
    `CHK("wire_free", 1'b1, reset_line)
    // reset in mid-run returns the outputs to their reset levels
    rstn = 0;
    cyc(3);
    `CHK("mid_rst_out", 1'b0, reset_n)
    `CHK("mid_rst_oe", 1'b1, strobe_pull_oe_n)
    rstn = 1;
    wait_rst(1, 150);
    `CHK("mid_rst_hold", 1'b1, n >= HC && n <= HC + 20)
    // supply loss asserts at once
    supply_good = 0;
    wait_rst(0, 10);
    `CHK("supply_drop", 1'b1, n <= 6)
    stop_test();
  end
endmodule
